// ==== hdl/led_sink_map.svh ====
// register map, bus address and timing constants for the led sink controller
// assumes inclusion by the package and the design files by bare name
`ifndef LED_SINK_MAP_SVH
`define LED_SINK_MAP_SVH
`define DEV_ADDR 7'h36
`define REG_BRIGHT 8'h00
`define REG_ENABLE 8'h01
`define BRIGHT_RESET 8'h00
`define ENABLE_RESET 5'h00
`define B_CODE_HI 7
`define B_CODE_LO 4
`define A_CODE_HI 3
`define A_CODE_LO 0
`define EN_B1_BIT 4
`define EN_B2_BIT 3
`define EN_A_HI 2
`define EN_A_LO 0
`define SOFT_START_US 300
`define CLOCK_MHZ 50
`define SOFT_START_CYCLES (`SOFT_START_US * `CLOCK_MHZ)
`endif

// ==== hdl/led_sink_pkg.sv ====
// types shared by the led sink controller files
// assumes led_sink_map.svh on the include path
`default_nettype none
`include "led_sink_map.svh"
package led_sink_pkg;
  // one register write crossing from the link domain
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_t;
  // settings presented to the analog sinks
  typedef struct packed {
    logic [3:0] group_b_level_code;
    logic [3:0] group_a_level_code;
    logic group_b_first_enable;
    logic group_b_second_enable;
    logic [2:0] group_a_enables;
  } sink_ctrl_t;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_DEVADDR = 5'h02,
    ST_REGADDR = 5'h04,
    ST_DATA = 5'h08,
    ST_IGNORE = 5'h10
  } link_state_t;
endpackage
`default_nettype wire

// ==== hdl/serial_write_target.sv ====
// two-wire write-only target: runs on the serial clock (scl) itself
// assumes scl only toggles inside frames; start/stop seen as sda edges while scl high
`default_nettype none
`include "led_sink_map.svh"
module serial_write_target
  import led_sink_pkg::*;
(
  input wire logic scl,
  input wire logic sda_in,
  input wire logic rst_n,
  output logic sda_out,
  output logic sda_oe,
  output reg_write_t wr,
  output logic wr_toggle
);
  logic start_seen;
  logic stop_seen;
  logic frame_rst_n;
  link_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [7:0] reg_addr;
  logic ack_slot;
  wire logic [7:0] next_shift = {shift[6:0], sda_in};
  wire logic byte_done = (bit_cnt == 4'h7);
  wire logic data_done = !ack_slot && state == ST_DATA && byte_done;
  // start: sda falls with scl high; cleared by a later sda fall with scl low
  always_ff @(negedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      start_seen <= 1'b0;
    end else begin
      start_seen <= scl;
    end
  end
  // stop: sda rises with scl high; ends frame without needing an scl edge
  always_ff @(posedge sda_in or negedge rst_n) begin
    if (!rst_n) begin
      stop_seen <= 1'b0;
    end else begin
      stop_seen <= scl;
    end
  end
  // a stop holds the frame in reset until the next start; a later sda rise clears it
  assign frame_rst_n = rst_n & ~(stop_seen & ~start_seen);
  always_ff @(posedge scl or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      reg_addr <= 8'h00;
      ack_slot <= 1'b0;
    end else if (start_seen && state == ST_IDLE) begin
      state <= ST_DEVADDR;
      shift <= next_shift;
      bit_cnt <= 4'h1;
      ack_slot <= 1'b0;
    end else if (ack_slot) begin
      ack_slot <= 1'b0;
      bit_cnt <= 4'h0;
    end else begin
      shift <= next_shift;
      bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
      if (byte_done) begin
        case (state)
          ST_DEVADDR: begin
            // address match and write direction only
            if (next_shift == {`DEV_ADDR, 1'b0}) begin // R1 R19
              state <= ST_REGADDR;
              ack_slot <= 1'b1; // R20
            end else begin
              state <= ST_IGNORE;
            end
          end
          ST_REGADDR: begin
            reg_addr <= next_shift; // R3
            state <= ST_DATA;
            ack_slot <= 1'b1; // R20
          end
          ST_DATA: begin
            ack_slot <= 1'b1; // R20
          end
          default: begin
            state <= ST_IGNORE;
          end
        endcase
      end
    end
  end
  // the written word sits outside the frame reset, so a stop cannot fake a write
  always_ff @(posedge scl or negedge rst_n) begin
    if (!rst_n) begin
      wr <= '0;
      wr_toggle <= 1'b0;
    end else if (data_done) begin
      wr <= '{addr: reg_addr, data: next_shift};
      wr_toggle <= ~wr_toggle; // R24
    end
  end
  // ack driven on falling scl so it is stable through the ninth high phase
  always_ff @(negedge scl or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= ack_slot; // R20
    end
  end
  assign sda_out = 1'b0;
endmodule
`default_nettype wire

// ==== hdl/led_sink_ctrl.sv ====
// led sink controller: register file, channel gating and boost switch sequencing
// assumes analog comparators arrive as async levels; scl/sda from open-drain pins
`default_nettype none
`include "led_sink_map.svh"
// Summary of operation
// R1: write-only target, never drives read data
// R2: master sends direction bit zero
// R3: master sends register address then data
// R4: two registers: brightness and sink enables
// R5: brightness register at address 0x00
// R6: bits 7:4 give group B level
// R7: bits 3:0 give group A level
// R8: codes 0-7 map 100 down to 31 percent
// R9: codes 8-15 map 26 down to 9 percent
// R10: group code scales every enabled sink equally
// R11: enable bits gate each sink independently
// R12: five sinks in two 16-level groups
// R13: disconnect on with supply, enable; soft start first
// R14: switching stops above current limit
// R15: over-temperature disables both switches, auto recovery
// R16: over-voltage halts switching until below hysteresis
// R17: undervoltage lockout holds off soft start
// R18: switch on to peak, off to valley
// R19: responds only to address 0x36
// R20: acknowledges address, register and data bytes
// R21: enable register at address 0x01
// R22: bits 4,3 backlight sinks; bits 2:0 aux sinks
// R23: unknown register writes acked, ignored
// R24: value takes effect after acked data byte
module led_sink_ctrl
  import led_sink_pkg::*;
#(
  parameter int SOFT_START_CYCLES = `SOFT_START_CYCLES
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic supply_ok,
  input wire logic current_limit,
  input wire logic over_temp,
  input wire logic overvoltage_sense_input,
  input wire logic peak_trip,
  input wire logic valley_trip,
  output logic disconnect_on,
  output logic low_switch_on,
  output logic soft_start_done,
  output sink_ctrl_t sinks,
  output logic [4:0] sink_on,
  output logic [6:0] group_a_percent_x10_hi,
  output logic [6:0] group_b_percent_x10_hi
);
  reg_write_t link_wr;
  logic link_toggle;
  logic [2:0] tog_sync;
  logic [7:0] bright;
  logic [4:0] enables;
  logic [3:0] uv_s1, uv_s2;
  logic [15:0] ss_cnt;
  logic switching;
  logic over_volt_latched;
  logic [1:0] trip_s1, trip_s2;

  serial_write_target u_link (
    .scl(scl),
    .sda_in(sda_in),
    .rst_n(rst_n),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr(link_wr),
    .wr_toggle(link_toggle)
  );

  // percent of full scale, in tenths of a percent then /10 kept as integer table
  function automatic logic [6:0] level_percent(input logic [3:0] code);
    logic [6:0] p;
    p = 7'd0;
    case (code)
      4'h0: p = 7'd100; // R8
      4'h1: p = 7'd84;
      4'h2: p = 7'd71;
      4'h3: p = 7'd60;
      4'h4: p = 7'd51;
      4'h5: p = 7'd43;
      4'h6: p = 7'd35;
      4'h7: p = 7'd31;
      4'h8: p = 7'd26; // R9
      4'h9: p = 7'd21;
      4'ha: p = 7'd18;
      4'hb: p = 7'd15;
      4'hc: p = 7'd13;
      4'hd: p = 7'd12;
      4'he: p = 7'd10;
      default: p = 7'd9;
    endcase
    return p;
  endfunction

  // toggle crossing: the written word is stable long before the toggle settles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tog_sync <= 3'h0;
    end else begin
      tog_sync <= {tog_sync[1:0], link_toggle};
    end
  end
  wire logic wr_event = tog_sync[2] ^ tog_sync[1];
  wire logic hit_bright = wr_event && link_wr.addr == `REG_BRIGHT; // R5
  wire logic hit_enable = wr_event && link_wr.addr == `REG_ENABLE; // R21

  // other addresses fall through untouched
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bright <= `BRIGHT_RESET;
      enables <= `ENABLE_RESET;
    end else begin
      if (hit_bright) begin
        bright <= link_wr.data; // R4 R24
      end
      if (hit_enable) begin
        enables <= link_wr.data[4:0]; // R4 R24
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sinks <= '0;
      sink_on <= 5'h00;
      group_a_percent_x10_hi <= 7'd0;
      group_b_percent_x10_hi <= 7'd0;
    end else begin
      sinks.group_b_level_code <= bright[`B_CODE_HI:`B_CODE_LO]; // R6
      sinks.group_a_level_code <= bright[`A_CODE_HI:`A_CODE_LO]; // R7
      sinks.group_b_first_enable <= enables[`EN_B1_BIT]; // R22
      sinks.group_b_second_enable <= enables[`EN_B2_BIT];
      sinks.group_a_enables <= enables[`EN_A_HI:`EN_A_LO];
      sink_on <= enables; // R11 R12
      group_a_percent_x10_hi <= level_percent(bright[`A_CODE_HI:`A_CODE_LO]); // R10
      group_b_percent_x10_hi <= level_percent(bright[`B_CODE_HI:`B_CODE_LO]); // R10
    end
  end

  // analog comparator levels: two flops each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      uv_s1 <= 4'h0;
      uv_s2 <= 4'h0;
    end else begin
      uv_s1 <= {supply_ok, current_limit, over_temp, overvoltage_sense_input};
      uv_s2 <= uv_s1;
    end
  end
  wire logic s_supply = uv_s2[3];
  wire logic s_ilim = uv_s2[2];
  wire logic s_hot = uv_s2[1];
  wire logic s_over_volt = uv_s2[0];

  // trips cross in from the analog side; two flops add latency to the peak cutoff
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trip_s1 <= 2'h0;
      trip_s2 <= 2'h0;
    end else begin
      trip_s1 <= {peak_trip, valley_trip};
      trip_s2 <= trip_s1;
    end
  end
  wire logic s_peak = trip_s2[1];
  wire logic s_valley = trip_s2[0];

  // enable pin is rst_n; supply must be valid before soft start runs
  wire logic [15:0] ss_last = 16'(SOFT_START_CYCLES - 1);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ss_cnt <= 16'h0000;
      soft_start_done <= 1'b0;
    end else if (!s_supply) begin
      ss_cnt <= 16'h0000; // R17
      soft_start_done <= 1'b0;
    end else if (ss_cnt == ss_last) begin
      soft_start_done <= 1'b1; // R13
    end else begin
      ss_cnt <= ss_cnt + 16'h0001;
    end
  end
  assign disconnect_on = s_supply && !s_hot; // R13 R15

  // comparator already carries hysteresis; the flop only delays the synced level by one clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      over_volt_latched <= 1'b0;
    end else begin
      over_volt_latched <= s_over_volt; // R16
    end
  end
  wire logic allow_sw = soft_start_done && !s_ilim && !s_hot && !over_volt_latched; // R14 R15 R16

  // synced peak/valley trips drive the hysteretic on/off control
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      switching <= 1'b0;
    end else if (!allow_sw) begin
      switching <= 1'b0;
    end else if (switching && s_peak) begin
      switching <= 1'b0; // R18
    end else if (!switching && s_valley) begin
      switching <= 1'b1; // R18
    end
  end
  assign low_switch_on = switching && allow_sw; // R14

  property p_no_switch_before_ss;
    @(posedge clock) disable iff (!rst_n) !soft_start_done |-> !low_switch_on;
  endproperty
  a_no_switch_before_ss: assert property (p_no_switch_before_ss) // R13
    else $error("switching before soft start");
  property p_uvlo;
    @(posedge clock) disable iff (!rst_n) !s_supply |=> !soft_start_done;
  endproperty
  a_uvlo: assert property (p_uvlo) // R17
    else $error("soft start done without supply");
  property p_ilim;
    @(posedge clock) disable iff (!rst_n) s_ilim |-> !low_switch_on;
  endproperty
  a_ilim: assert property (p_ilim) // R14
    else $error("switching over current limit");
  property p_hot;
    @(posedge clock) disable iff (!rst_n) s_hot |-> !low_switch_on && !disconnect_on;
  endproperty
  a_hot: assert property (p_hot) // R15
    else $error("switch on while hot");
  property p_over_volt;
    @(posedge clock) disable iff (!rst_n) s_over_volt |=> !low_switch_on;
  endproperty
  a_over_volt: assert property (p_over_volt) // R16
    else $error("switching during over-voltage");
  property p_bright;
    @(posedge clock) disable iff (!rst_n)
      hit_bright |=> ##1 sinks.group_b_level_code == $past(link_wr.data[7:4], 2);
  endproperty
  a_bright: assert property (p_bright) // R6
    else $error("group b code not applied");
  property p_enable;
    @(posedge clock) disable iff (!rst_n)
      hit_enable |=> ##1 sink_on == $past(link_wr.data[4:0], 2);
  endproperty
  a_enable: assert property (p_enable) // R22
    else $error("enables not applied");
  property p_ignore;
    @(posedge clock) disable iff (!rst_n)
      wr_event && link_wr.addr > 8'h01 |=> $stable(bright) && $stable(enables);
  endproperty
  a_ignore: assert property (p_ignore) // R23
    else $error("unknown address changed a register");
  property p_group_a;
    @(posedge clock) disable iff (!rst_n)
      hit_bright |=> ##1 sinks.group_a_level_code == $past(link_wr.data[3:0], 2);
  endproperty
  a_group_a: assert property (p_group_a) // R7
    else $error("group a code not applied");
  property p_enable_fields;
    @(posedge clock) disable iff (!rst_n)
      hit_enable |=> ##1 {sinks.group_b_first_enable, sinks.group_b_second_enable,
        sinks.group_a_enables} == $past(link_wr.data[4:0], 2);
  endproperty
  a_enable_fields: assert property (p_enable_fields) // R22
    else $error("sink enable fields not applied");
  property p_uvlo_switch;
    @(posedge clock) disable iff (!rst_n)
      !s_supply |=> !low_switch_on;
  endproperty
  a_uvlo_switch: assert property (p_uvlo_switch) // R17
    else $error("switching after supply loss");
  property p_ss_length;
    @(posedge clock) disable iff (!rst_n)
      $rose(soft_start_done) |-> ss_cnt == ss_last;
  endproperty
  a_ss_length: assert property (p_ss_length) // R13
    else $error("soft start ended early");
  property p_peak;
    @(posedge clock) disable iff (!rst_n)
      switching && s_peak |=> !low_switch_on;
  endproperty
  a_peak: assert property (p_peak) // R18
    else $error("switch stayed on past peak");
  property p_valley;
    @(posedge clock) disable iff (!rst_n)
      allow_sw && !switching && s_valley |=> switching;
  endproperty
  a_valley: assert property (p_valley) // R18
    else $error("switch did not restart at valley");
  property p_ilim_restart;
    @(posedge clock) disable iff (!rst_n)
      $fell(s_ilim) && allow_sw && s_valley |=> switching;
  endproperty
  a_ilim_restart: assert property (p_ilim_restart) // R14
    else $error("switching did not resume after current limit");
endmodule
`default_nettype wire

// ==== bench/bus_master_model.sv ====
// serial bus master model: drives scl and pulls sda low, scl stands still between frames
// assumes the bench resolves sda from all pull-downs with a pull-up
`default_nettype none
module bus_master_model (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 10ps;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // sda falls while scl is high
  task automatic start();
    sda_low = 1'b1;
    #7.5 scl = 1'b0;
  endtask
  // msb first, sda only moves while scl is low; ninth slot released for the ack
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #3.75 sda_low = ~b[i];
      #3.75 scl = 1'b1;
      #7.5 scl = 1'b0;
    end
    #3.75 sda_low = 1'b0;
    #3.75 scl = 1'b1;
    ack = ~sda;
    #7.5 scl = 1'b0;
  endtask
  // sda rises while scl is high
  task automatic stop();
    #3.75 sda_low = 1'b1;
    #3.75 scl = 1'b1;
    #7.5 sda_low = 1'b0;
    #15;
  endtask
endmodule
`default_nettype wire

// ==== bench/i2c_led_sink_control_tb.sv ====
// bench for the led sink controller: serial writes, sink settings, switch gating
// assumes bus_master_model on the serial side and a pull-up on sda
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_count++; \
  $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp); end end
module i2c_led_sink_control_tb
  import led_sink_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rst_n, supply_ok, current_limit, over_temp, over_volt, peak_trip, valley_trip;
  logic scl, m_low, sda_out, sda_oe, disconnect_on, low_switch_on, soft_start_done;
  logic [4:0] sink_on;
  logic [6:0] pct_a, pct_b;
  sink_ctrl_t sinks;
  wire sda;
  int err_count, n_compared, cnt;
  logic [31:0] lfsr;
  logic [7:0] bright, en;
  // {supply, limit, hot, ov, peak, valley, switch, disconnect}
  logic [7:0] sw_tab [11] = '{8'h87, 8'h89, 8'h81, 8'h87, 8'hc5, 8'h87, 8'ha4, 8'h87,
    8'h95, 8'h87, 8'h04};
  logic [6:0] pct_tab [16] = '{7'h64, 7'h54, 7'h47, 7'h3c, 7'h33, 7'h2b, 7'h23, 7'h1f,
    7'h1a, 7'h15, 7'h12, 7'h0f, 7'h0d, 7'h0c, 7'h0a, 7'h09};
  // open drain: low if either party pulls
  assign sda = ~(m_low | sda_oe);
  // short soft start keeps the run brief
  led_sink_ctrl #(.SOFT_START_CYCLES(20)) DUT (.clock(clock), .rst_n(rst_n), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .supply_ok(supply_ok),
    .current_limit(current_limit), .over_temp(over_temp), .overvoltage_sense_input(over_volt),
    .peak_trip(peak_trip), .valley_trip(valley_trip), .disconnect_on(disconnect_on),
    .low_switch_on(low_switch_on), .soft_start_done(soft_start_done), .sinks(sinks),
    .sink_on(sink_on), .group_a_percent_x10_hi(pct_a), .group_b_percent_x10_hi(pct_b));
  bus_master_model master (.scl(scl), .sda_low(m_low), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check_outputs();
    repeat (8) @(posedge clock);
    #1;
    `CHK(sinks.group_b_level_code, bright[7:4])
    `CHK(sinks.group_a_level_code, bright[3:0])
    `CHK(sinks[4:0], en[4:0])
    `CHK(sink_on, en[4:0])
    `CHK(pct_a, pct_tab[bright[3:0]])
    `CHK(pct_b, pct_tab[bright[7:4]])
    `CHK(sda_out, 1'b0)
  endtask
  // every data byte of a frame goes to the same register
  task automatic frame(input logic [7:0] dev, input logic [7:0] ra, input logic [7:0] d,
      input int n);
    logic ack;
    logic ok;
    logic [7:0] b;
    ok = (dev === 8'h6c);
    master.start();
    master.send(dev, ack);
    `CHK(ack, ok)
    for (int i = 0; i <= n; i++) begin
      if (i == 1) check_outputs();
      b = (i == 0) ? ra : d + 8'(i - 1);
      master.send(b, ack);
      `CHK(ack, ok)
      if (ok && i > 0 && ra == 8'h00) bright = b;
      if (ok && i > 0 && ra == 8'h01) en = {3'h0, b[4:0]};
    end
    master.stop();
    check_outputs();
  endtask
  initial begin
    {rst_n, supply_ok, current_limit, over_temp, over_volt, peak_trip, valley_trip} = 7'h00;
    {bright, en, lfsr} = {16'h0000, 32'h219c};
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    check_outputs();
    `CHK({disconnect_on, soft_start_done, low_switch_on}, 3'h0)
    @(posedge clock);
    supply_ok <= 1'b1;
    for (cnt = 0; cnt < 200 && soft_start_done !== 1'b1; cnt++) begin
      @(posedge clock);
      #1;
    end
    `CHK(cnt >= 20 && cnt < 200, 1'b1)
    if (cnt >= 200) stop_test();
    frame(8'h6c, 8'h00, 8'h4b, 1);
    frame(8'h6c, 8'h01, 8'h1f, 1);
    frame(8'h6c, 8'h01, 8'h1d, 2);
    frame(8'h6e, 8'h00, 8'hff, 1);
    frame(8'h6d, 8'h00, 8'hff, 1);
    frame(8'h6c, 8'h02, 8'haa, 1);
    frame(8'h6c, 8'hff, 8'h55, 1);
    for (int k = 0; k < 16; k++) frame(8'h6c, 8'h00, {4'(k), 4'(15 - k)}, 1);
    for (int k = 0; k < 24; k++) begin
      lfsr = next_rand(lfsr);
      frame(lfsr[4] ? 8'h6c : lfsr[23:16], (lfsr[3:2] == 2'h0) ? lfsr[15:8] : {7'h0, lfsr[0]},
        lfsr[31:24], 1);
    end
    foreach (sw_tab[k]) begin
      @(posedge clock);
      {supply_ok, current_limit, over_temp, over_volt, peak_trip, valley_trip} <= sw_tab[k][7:2];
      repeat (30) @(posedge clock);
      #1;
      `CHK(low_switch_on, sw_tab[k][1])
      `CHK(disconnect_on, sw_tab[k][0])
      `CHK(soft_start_done, sw_tab[k][7])
    end
    stop_test();
  end
endmodule
`default_nettype wire
